// file: include/display_memory_pkg.sv
// Constants shared by the shared display memory interface and its byte memory.
package display_memory_pkg;

   // Physical memory geometry.
   localparam int          MEM_AW         = 11;
   localparam int          MEM_DEPTH      = 2048;

   // External data space windows.
   localparam logic [15:0] AUX_LAST       = 16'h02ff;
   localparam logic [15:0] TEXT_BASE      = 16'h2000;
   localparam logic [15:0] TEXT_LAST      = 16'h24ff;
   localparam logic [15:0] CAPT_BASE      = 16'h8000;
   localparam logic [15:0] CAPT_LAST      = 16'h84ff;

   // Physical placement of the display area behind the auxiliary area.
   localparam logic [10:0] DISP_PHYS_BASE = 11'h300;

   // Page clearing.
   localparam logic [7:0]  CLEAR_BYTE     = 8'h20;
   localparam logic [9:0]  CLEAR_LAST     = 10'h3ff;

   // Row and column geometry of the text layout.
   localparam logic [5:0]  COL_LAST       = 6'h27;
   localparam logic [4:0]  ROW_WRAP       = 5'h19;
   localparam logic [5:0]  COL_WRAP       = 6'h17;
   localparam logic [5:0]  COL_SPLIT      = 6'h20;
   localparam logic [9:0]  HIGH_COL_BASE  = 10'h3f8;

   // Register port selects.
   localparam logic [1:0]  SEL_ROW        = 2'h0;
   localparam logic [1:0]  SEL_COL        = 2'h1;
   localparam logic [1:0]  SEL_DATA       = 2'h2;

   // Reset values of the position registers.
   localparam logic [4:0]  ROW_RESET      = 5'h00;
   localparam logic [5:0]  COL_RESET      = 6'h00;

endpackage : display_memory_pkg

// file: src/shared_byte_ram.sv
// Single-port byte memory with registered read data, holding auxiliary and display storage.
`timescale 1ns/1ps

module shared_byte_ram
(
   // Clock and reset
   input  wire logic                                  core_clk,
   input  wire logic                                  rst_n,
   // Access port
   input  wire logic                                  memEn,
   input  wire logic                                  memWe,
   input  wire logic [display_memory_pkg::MEM_AW-1:0] memAddr,
   input  wire logic [7:0]                            memWdata,
   output logic      [7:0]                            memQ
);
   import display_memory_pkg::*;

   // The array has no reset so that auxiliary contents stay uninitialised after power-up.
   logic [7:0] store [MEM_DEPTH];

   always_ff @(posedge core_clk)
   begin
      if (memEn && memWe)
      begin
         store[memAddr] <= memWdata;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         memQ <= 8'h00;
      end
      else if (memEn && !memWe)
      begin
         memQ <= store[memAddr];
      end
   end

endmodule : shared_byte_ram

// file: src/display_memory_interface.sv
// Arbiter, address decoder, indirect row/column port and page clearing for the shared display memory.
`timescale 1ns/1ps

module display_memory_interface
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Display mode control
   input  wire logic        captionLayoutMode,
   // External data move port
   input  wire logic        xReq,
   input  wire logic        xWrite,
   input  wire logic [15:0] xAddr,
   input  wire logic [7:0]  xWdata,
   output logic             xAck,
   // Register port for row, column and data
   input  wire logic        sfrReq,
   input  wire logic        sfrWrite,
   input  wire logic [1:0]  sfrSel,
   input  wire logic [7:0]  sfrWdata,
   output logic             sfrAck,
   // Shared microcontroller answer
   output logic             cpuBusy,
   output logic [7:0]       cpuRdata,
   // Display section reads
   input  wire logic        dispReq,
   input  wire logic [10:0] dispAddr,
   output logic             dispGnt,
   output logic             dispValid,
   output logic [7:0]       dispRdata,
   // Data capture section accesses
   input  wire logic        capReq,
   input  wire logic        capWe,
   input  wire logic [10:0] capAddr,
   input  wire logic [7:0]  capWdata,
   output logic             capGnt,
   output logic             capValid,
   output logic [7:0]       capRdata,
   // Status
   output logic             pageClearInProgress
);
   import display_memory_pkg::*;

   // Ten-bit offset of a text position within a display block.
   function automatic logic [9:0] text_offset(input logic [4:0] row, input logic [5:0] col);
      logic [9:0] high;
      high = HIGH_COL_BASE - {2'b00, row, 3'b000} + {7'b0000000, col[2:0]};
      if (col < COL_SPLIT)
      begin
         return {row, col[4:0]};
      end
      return high;
   endfunction : text_offset

   // State.
   logic        pend_q;
   logic        pendMem_q;
   logic        pendWe_q;
   logic        pendSfr_q;
   logic [10:0] pendAddr_q;
   logic [7:0]  pendWdata_q;
   logic [7:0]  pendReg_q;
   logic [4:0]  row_q;
   logic [5:0]  col_q;
   logic        clearActive_q;
   logic [9:0]  clearCnt_q;
   logic        cpuIssued_q;
   logic        dispIssued_q;
   logic        capIssued_q;
   logic        xAck_q;
   logic        sfrAck_q;
   logic [7:0]  cpuRdata_q;
   logic [7:0]  memQ;

   // External data decode.
   wire         auxHit    = (xAddr <= AUX_LAST);
   wire         textHit   = !captionLayoutMode && (xAddr >= TEXT_BASE) && (xAddr <= TEXT_LAST);
   wire         captHit   = captionLayoutMode && (xAddr >= CAPT_BASE) && (xAddr <= CAPT_LAST);
   wire         xMapped   = auxHit || textHit || captHit;
   wire  [15:0] textOff   = xAddr - TEXT_BASE;
   wire  [15:0] captOff   = xAddr - CAPT_BASE;
   wire  [10:0] winOff    = textHit ? textOff[10:0] : captOff[10:0];
   wire  [10:0] xPhys     = auxHit ? xAddr[10:0] : DISP_PHYS_BASE + winOff;

   // Indirect port decode.
   wire         portHit   = (sfrSel == SEL_DATA);
   wire  [10:0] sfrPhys   = DISP_PHYS_BASE + {1'b0, text_offset(row_q, col_q)};
   wire  [7:0]  sfrRegRd  = (sfrSel == SEL_ROW) ? {3'h0, row_q} : (sfrSel == SEL_COL) ? {2'h0, col_q} : 8'h00;
   wire         atWrap    = (row_q == ROW_WRAP) && (col_q == COL_WRAP);
   wire         atColLast = (col_q == COL_LAST);
   wire  [4:0]  rowInc    = row_q + 5'h01;
   wire  [5:0]  colInc    = col_q + 6'h01;
   wire  [4:0]  rowNext   = atWrap ? ROW_RESET : atColLast ? rowInc : row_q;
   wire  [5:0]  colNext   = (atWrap || atColLast) ? COL_RESET : colInc;

   // Request acceptance; an external data move wins over a register access in the same cycle.
   wire         xTake     = xReq && !pend_q;
   wire         sfrTake   = sfrReq && !xReq && !pend_q;
   wire         portTake  = sfrTake && portHit;

   // Arbitration: clearing first, then capture, then display, then the microcontroller.
   wire         capGrant  = capReq && !clearActive_q;
   wire         dispGrant = dispReq && !capReq && !clearActive_q;
   wire         cpuGrant  = pend_q && pendMem_q && !cpuIssued_q && !clearActive_q && !capReq && !dispReq;
   wire         cpuDone   = pend_q && (!pendMem_q || cpuIssued_q);

   // Memory port selection.
   wire         memEn     = clearActive_q || capGrant || dispGrant || cpuGrant;
   wire         memWe     = clearActive_q || (capGrant && capWe) || (cpuGrant && pendWe_q);
   wire  [10:0] clearPhys = DISP_PHYS_BASE + {1'b0, clearCnt_q};
   wire  [10:0] capPhys   = DISP_PHYS_BASE + capAddr;
   wire  [10:0] dispPhys  = DISP_PHYS_BASE + dispAddr;
   wire  [10:0] memAddr   = clearActive_q ? clearPhys : capGrant ? capPhys : dispGrant ? dispPhys : pendAddr_q;
   wire  [7:0]  memWdata  = clearActive_q ? CLEAR_BYTE : capGrant ? capWdata : pendWdata_q;

   shared_byte_ram u_ram
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .memEn    (memEn),
      .memWe    (memWe),
      .memAddr  (memAddr),
      .memWdata (memWdata),
      .memQ     (memQ)
   );

   // Pending microcontroller request; the position used is the one before the increment.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pend_q      <= 1'b0;
         pendMem_q   <= 1'b0;
         pendWe_q    <= 1'b0;
         pendSfr_q   <= 1'b0;
         pendAddr_q  <= 11'h000;
         pendWdata_q <= 8'h00;
         pendReg_q   <= 8'h00;
      end
      else if (xTake)
      begin
         pend_q      <= 1'b1;
         pendMem_q   <= xMapped;
         pendWe_q    <= xWrite;
         pendSfr_q   <= 1'b0;
         pendAddr_q  <= xPhys;
         pendWdata_q <= xWdata;
         pendReg_q   <= 8'h00;
      end
      else if (sfrTake)
      begin
         pend_q      <= 1'b1;
         pendMem_q   <= portHit;
         pendWe_q    <= sfrWrite;
         pendSfr_q   <= 1'b1;
         pendAddr_q  <= sfrPhys;
         pendWdata_q <= sfrWdata;
         pendReg_q   <= sfrRegRd;
      end
      else if (cpuDone)
      begin
         pend_q      <= 1'b0;
      end
   end

   // Row and column position registers.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         row_q <= ROW_RESET;
         col_q <= COL_RESET;
      end
      else if (portTake)
      begin
         row_q <= rowNext;
         col_q <= colNext;
      end
      else if (sfrTake && sfrWrite)
      begin
         if (sfrSel == SEL_ROW)
         begin
            row_q <= sfrWdata[4:0];
         end
         if (sfrSel == SEL_COL)
         begin
            col_q <= sfrWdata[5:0];
         end
      end
   end

   // Page clear runs once after every reset, so a reset exit from idle refills the text page.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         clearActive_q <= 1'b1;
         clearCnt_q    <= 10'h000;
      end
      else if (clearActive_q)
      begin
         clearCnt_q <= clearCnt_q + 10'h001;
         if (clearCnt_q == CLEAR_LAST)
         begin
            clearActive_q <= 1'b0;
         end
      end
   end

   // Issue tracking and answers.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cpuIssued_q  <= 1'b0;
         dispIssued_q <= 1'b0;
         capIssued_q  <= 1'b0;
         xAck_q       <= 1'b0;
         sfrAck_q     <= 1'b0;
         cpuRdata_q   <= 8'h00;
      end
      else
      begin
         cpuIssued_q  <= cpuGrant;
         dispIssued_q <= dispGrant;
         capIssued_q  <= capGrant;
         xAck_q       <= cpuDone && !pendSfr_q;
         sfrAck_q     <= cpuDone && pendSfr_q;
         if (cpuDone)
         begin
            cpuRdata_q <= (pendMem_q && !pendWe_q) ? memQ : pendReg_q;
         end
      end
   end

   assign xAck                = xAck_q;
   assign sfrAck              = sfrAck_q;
   assign cpuBusy             = pend_q;
   assign cpuRdata            = cpuRdata_q;
   assign dispGnt             = dispGrant;
   assign dispValid           = dispIssued_q;
   assign dispRdata           = memQ;
   assign capGnt              = capGrant;
   assign capValid            = capIssued_q;
   assign capRdata            = memQ;
   assign pageClearInProgress = clearActive_q;

   // Checks.
   clear_write_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      clearActive_q |-> memWe && memWdata == 8'h20 && memAddr == 11'h300 + {1'b0, clearCnt_q})
      else $error("page clear does not write the fill byte");

   clear_end_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      clearActive_q && clearCnt_q == 10'h3ff |=> !clearActive_q && !pageClearInProgress)
      else $error("page clear flag outlives the clear");

   cpu_stall_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      (capReq || dispReq || clearActive_q) |=> !cpuIssued_q)
      else $error("microcontroller access taken while another section wanted memory");

   pos_wrap_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      portTake && row_q == 5'h19 && col_q == 6'h17 |=> row_q == 5'h00 && col_q == 6'h00)
      else $error("position did not return to origin");

   col_wrap_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      portTake && row_q < 5'h19 && col_q == 6'h27 |=> col_q == 6'h00 && row_q == $past(row_q) + 5'h01)
      else $error("column wrap did not advance row");

   pre_inc_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      portTake |=> pendAddr_q == 11'h300 + {1'b0, text_offset($past(row_q), $past(col_q))})
      else $error("data port used post-increment position");

   unmapped_rd_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      xTake && !xMapped && !xWrite |-> ##2 xAck && cpuRdata == 8'h00 && !sfrAck)
      else $error("unmapped read did not answer zero");

   window_alias_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      xTake && (textHit || captHit) |=> pendAddr_q == 11'h300 + ($past(captionLayoutMode) ?
      $past(captOff[10:0]) : $past(textOff[10:0])))
      else $error("display windows do not share physical bytes");

   cpu_answer_a : assert property (@(posedge core_clk) disable iff (!rst_n)
      cpuIssued_q |=> (xAck || sfrAck) && !cpuBusy)
      else $error("issued access not answered");

endmodule : display_memory_interface

// file: bench/mem_requester_model.sv
// Behavioural requester standing in for the display or the data capture section.
`timescale 1ns/1ps

module mem_requester_model
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Bench control
   input  wire logic        start,
   input  wire logic        wr,
   input  wire logic [10:0] addrIn,
   input  wire logic [7:0]  dataIn,
   output logic             done,
   output logic [7:0]       got,
   // Memory side
   input  wire logic        gnt,
   input  wire logic        valid,
   input  wire logic [7:0]  rdata,
   output logic             req,
   output logic             we,
   output logic [10:0]      addr,
   output logic [7:0]       wdata
);
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         req <= 1'b0;
         done <= 1'b0;
         addr <= 11'h000;
      end
      else if (req && gnt)
      begin
         // Released lines show the inverse so a stale value is never taken for a live one.
         req <= 1'b0;
         we <= ~we;
         addr <= ~addr;
         wdata <= ~wdata;
      end
      else if (start && !req)
      begin
         req <= 1'b1;
         we <= wr;
         addr <= addrIn;
         wdata <= dataIn;
         done <= 1'b0;
      end
      if (valid)
      begin
         got <= rdata;
         done <= 1'b1;
      end
   end
endmodule : mem_requester_model

// file: bench/display_memory_interface_tb_top.sv
// Self-checking testbench for the shared display memory interface.
`timescale 1ns/1ps

module display_memory_interface_tb_top;
   import display_memory_pkg::*;

   logic        core_clk = 1'b0, rst_n = 1'b0, captionLayoutMode = 1'b0;
   logic        xReq = 1'b0, xWrite = 1'b0, sfrReq = 1'b0, sfrWrite = 1'b0;
   logic        dStart = 1'b0, cStart = 1'b0, cWr = 1'b0, dDone, cDone;
   logic        xAck, sfrAck, cpuBusy, dispReq, dispGnt, dispValid, capReq, capWe, capGnt, capValid;
   logic        pageClearInProgress;
   logic [15:0] xAddr = 16'h0000;
   logic [1:0]  sfrSel = 2'h0;
   logic [10:0] dispAddr, capAddr, mAddr = 11'h000;
   logic [7:0]  xWdata = 8'h00, sfrWdata = 8'h00, mData = 8'h00, q;
   logic [7:0]  cpuRdata, dispRdata, capRdata, capWdata, dGot, cGot;
   int          fail_count = 0;
   int          comparisons = 0;

   always #2 core_clk = ~core_clk;

   display_memory_interface u_display_memory_interface
   (
      .core_clk(core_clk), .rst_n(rst_n), .captionLayoutMode(captionLayoutMode),
      .xReq(xReq), .xWrite(xWrite), .xAddr(xAddr), .xWdata(xWdata), .xAck(xAck),
      .sfrReq(sfrReq), .sfrWrite(sfrWrite), .sfrSel(sfrSel), .sfrWdata(sfrWdata), .sfrAck(sfrAck),
      .cpuBusy(cpuBusy), .cpuRdata(cpuRdata),
      .dispReq(dispReq), .dispAddr(dispAddr), .dispGnt(dispGnt), .dispValid(dispValid), .dispRdata(dispRdata),
      .capReq(capReq), .capWe(capWe), .capAddr(capAddr), .capWdata(capWdata), .capGnt(capGnt),
      .capValid(capValid), .capRdata(capRdata), .pageClearInProgress(pageClearInProgress)
   );

   mem_requester_model u_mem_requester_model_disp
   (
      .core_clk(core_clk), .rst_n(rst_n), .start(dStart), .wr(1'b0), .addrIn(mAddr), .dataIn(mData),
      .done(dDone), .got(dGot), .gnt(dispGnt), .valid(dispValid), .rdata(dispRdata),
      .req(dispReq), .we(), .addr(dispAddr), .wdata()
   );

   mem_requester_model u_mem_requester_model_cap
   (
      .core_clk(core_clk), .rst_n(rst_n), .start(cStart), .wr(cWr), .addrIn(mAddr), .dataIn(mData),
      .done(cDone), .got(cGot), .gnt(capGnt), .valid(capValid), .rdata(capRdata),
      .req(capReq), .we(capWe), .addr(capAddr), .wdata(capWdata)
   );

   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task test_done;
      $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   // One strobe, then wait for either acknowledge; entered and left just after a rising edge.
   task acc(input logic s, input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
      int n;
      xReq = !s;
      sfrReq = s;
      xWrite = w;
      sfrWrite = w;
      xAddr = a;
      sfrSel = a[1:0];
      xWdata = d;
      sfrWdata = d;
      @(posedge core_clk);
      #1;
      xReq = 1'b0;
      sfrReq = 1'b0;
      n = 0;
      while (!(xAck | sfrAck) && n < 3000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 3000)
         fail_count++;
      r = cpuRdata;
   endtask : acc

   task xw(input logic [15:0] a, input logic [7:0] d);
      acc(1'b0, 1'b1, a, d, q);
   endtask : xw

   task sw(input logic [1:0] s, input logic [7:0] d);
      acc(1'b1, 1'b1, {14'h0000, s}, d, q);
   endtask : sw

   task xchk(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, 1'b0, a, 8'h00, q);
      check({8'h00, q}, {8'h00, e});
   endtask : xchk

   task schk(input logic [1:0] s, input logic [7:0] e);
      acc(1'b1, 1'b0, {14'h0000, s}, 8'h00, q);
      check({8'h00, q}, {8'h00, e});
   endtask : schk

   task wait_done(input logic cap);
      int n;
      n = 0;
      while (!(cap ? cDone : dDone) && n < 100)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(n < 100, 1'b1);
   endtask : wait_done

   task test_reset;
      int n;
      rst_n = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      n = 0;
      while (pageClearInProgress === 1'b1 && n < 2000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(n[15:0], 16'h0400);
      xchk(16'h2000, CLEAR_BYTE);
      xchk(16'h23ff, CLEAR_BYTE);
      $display("reset and page clear test finished");
   endtask : test_reset

   task test_map;
      xw(16'h0000, 8'ha1);
      xw(16'h02ff, 8'ha2);
      xw(16'h0300, 8'ha3);
      xchk(16'h0000, 8'ha1);
      xchk(16'h02ff, 8'ha2);
      xchk(16'h0300, 8'h00);
      $display("auxiliary map test finished");
   endtask : test_map

   task test_windows;
      xw(16'h2100, 8'h5a);
      captionLayoutMode = 1'b1;
      xchk(16'h8100, 8'h5a);
      xw(16'h84ff, 8'hc3);
      xchk(16'h2000, 8'h00);
      captionLayoutMode = 1'b0;
      xchk(16'h24ff, 8'hc3);
      xchk(16'h84ff, 8'h00);
      $display("window test finished");
   endtask : test_windows

   task test_port;
      sw(SEL_ROW, 8'h01);
      sw(SEL_COL, 8'h27);
      sw(SEL_DATA, 8'h11);
      schk(SEL_ROW, 8'h02);
      schk(SEL_COL, 8'h00);
      xchk(16'h23f7, 8'h11);
      xw(16'h2040, 8'h77);
      schk(SEL_DATA, 8'h77);
      schk(SEL_COL, 8'h01);
      sw(SEL_ROW, 8'h19);
      sw(SEL_COL, 8'h17);
      sw(SEL_DATA, 8'he4);
      schk(SEL_ROW, 8'h00);
      schk(SEL_COL, 8'h00);
      xchk(16'h2337, 8'he4);
      sw(SEL_COL, 8'h1f);
      sw(SEL_DATA, 8'h31);
      sw(SEL_DATA, 8'h32);
      xchk(16'h201f, 8'h31);
      xchk(16'h23f8, 8'h32);
      schk(2'h3, 8'h00);
      $display("register port test finished");
   endtask : test_port

   // Both sections raise their requests at the edge that takes the read, so the read has to wait behind them.
   task test_share;
      mAddr = 11'h123;
      mData = 8'h9c;
      cWr = 1'b1;
      cStart = 1'b1;
      dStart = 1'b1;
      fork
         xchk(16'h2123, 8'h9c);
         begin
            @(posedge core_clk);
            #1;
            cStart = 1'b0;
            dStart = 1'b0;
            check({15'h0000, capGnt}, 16'h0001);
            @(posedge core_clk);
            #1;
            check({14'h0000, cpuBusy, dispGnt}, 16'h0003);
         end
      join
      wait_done(1'b1);
      wait_done(1'b0);
      check({8'h00, dGot}, 16'h009c);
      cWr = 1'b0;
      cStart = 1'b1;
      @(posedge core_clk);
      #1;
      cStart = 1'b0;
      wait_done(1'b1);
      check({8'h00, cGot}, 16'h009c);
      $display("sharing test finished");
   endtask : test_share

   task test_rereset;
      xw(16'h0010, 8'h66);
      xw(16'h2005, 8'h55);
      test_reset;
      xchk(16'h0010, 8'h66);
      xchk(16'h2005, CLEAR_BYTE);
      $display("second reset test finished");
   endtask : test_rereset

   initial
   begin
      test_reset;
      test_map;
      test_windows;
      test_port;
      test_share;
      test_rereset;
      test_done;
   end

   // Two page clears and a few dozen accesses need far less than this.
   initial
   begin
      #200000;
      fail_count++;
      test_done;
   end
endmodule : display_memory_interface_tb_top
